// >>> common/dpram_defines.vh
// Constants for the dual-port block RAM and its configuration registers
`ifndef DPRAM_DEFINES_VH
`define DPRAM_DEFINES_VH

// =====================================================
// Register byte offsets
`define OFS_CFG_A 8'h00
`define OFS_SRV_A 8'h04
`define OFS_DOUT_A 8'h08
`define OFS_CFG_B 8'h0c
`define OFS_SRV_B 8'h10
`define OFS_DOUT_B 8'h14
`define OFS_DPAR 8'h18

// =====================================================
// Configuration register fields
`define CFG_WIDTH_LO 0
`define CFG_WIDTH_HI 2
`define CFG_MODE_LO 3
`define CFG_MODE_HI 4
`define CFG_CLK_FALL 5
`define CFG_EN_LOW 6
`define CFG_WE_LOW 7
`define CFG_SSR_LOW 8
`define CFG_SRPAR_LO 12
`define CFG_SRPAR_HI 15

// =====================================================
// Reset values
`define CFG_RST 16'h0005
`define SRV_RST 32'h00000000

// =====================================================
// Width codes
`define W_1 3'h0
`define W_2 3'h1
`define W_4 3'h2
`define W_9 3'h3
`define W_18 3'h4
`define W_36 3'h5

// =====================================================
// Write modes
`define MODE_WRITE_FIRST 2'h0
`define MODE_READ_FIRST 2'h1
`define MODE_NO_CHANGE 2'h2

// =====================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> verilog/port_edge_gen.v
// Active-edge detector for one port clock sampled by the system clock
`timescale 1ns/1ps
module port_edge_gen (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_port_clk,
    input wire i_falling,
    output wire o_edge
);
    // Last sampled port clock level
    reg prev_reg;
    // Set one cycle after reset so a high clock at release is no edge
    reg armed_reg;

    // =====================================================
    // Sample history
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            prev_reg <= i_port_clk;
            armed_reg <= 1'b1;
        end
    end

    assign o_edge = armed_reg & (i_falling ? (prev_reg & ~i_port_clk) : (~prev_reg & i_port_clk));
endmodule

// >>> verilog/word_lane_map.v
// Maps a port address at its width onto a 36-bit storage word
`timescale 1ns/1ps
`include "dpram_defines.vh"
module word_lane_map (
    input wire [2:0] i_width,
    input wire [13:0] i_addr,
    input wire [31:0] i_wdat,
    input wire [3:0] i_wpar,
    input wire [35:0] i_rword,
    output reg [8:0] o_idx,
    output wire [35:0] o_mask,
    output wire [35:0] o_wword,
    output wire [31:0] o_rdat,
    output wire [3:0] o_rpar,
    output wire [31:0] o_wr_dat,
    output wire [3:0] o_wr_par
);
    // Data lane shift, data mask, parity shift, parity mask
    reg [4:0] sh;
    reg [31:0] dm;
    reg [1:0] ps;
    reg [3:0] pm;

    // =====================================================
    // Width decode
    // little-endian slice placement
    always @* begin
        o_idx = i_addr[8:0];
        sh = 5'h00;
        dm = 32'hffffffff;
        ps = 2'h0;
        pm = 4'hf;
        // six aspect ratios via width code
        case (i_width)
            `W_1: begin
                o_idx = i_addr[13:5];
                sh = i_addr[4:0];
                dm = 32'h00000001;
                pm = 4'h0;
            end
            `W_2: begin
                o_idx = i_addr[12:4];
                sh = {i_addr[3:0], 1'b0};
                dm = 32'h00000003;
                pm = 4'h0;
            end
            `W_4: begin
                o_idx = i_addr[11:3];
                sh = {i_addr[2:0], 2'h0};
                dm = 32'h0000000f;
                pm = 4'h0;
            end
            `W_9: begin
                o_idx = i_addr[10:2];
                sh = {i_addr[1:0], 3'h0};
                dm = 32'h000000ff;
                ps = i_addr[1:0];
                pm = 4'h1;
            end
            `W_18: begin
                o_idx = i_addr[9:1];
                sh = {i_addr[0], 4'h0};
                dm = 32'h0000ffff;
                ps = {i_addr[0], 1'b0};
                pm = 4'h3;
            end
            default: begin
                o_idx = i_addr[8:0];
            end
        endcase
    end

    // narrow widths never touch parity lanes
    assign o_mask = {pm << ps, dm << sh};
    assign o_wr_dat = i_wdat & dm;
    assign o_wr_par = i_wpar & pm;
    assign o_wword = {o_wr_par << ps, o_wr_dat << sh};
    assign o_rdat = (i_rword[31:0] >> sh) & dm;
    assign o_rpar = (i_rword[35:32] >> ps) & pm;
endmodule

// >>> verilog/dual_port_block_ram.v
// Dual-port 18 Kb block RAM with AXI4-Lite configuration registers
`timescale 1ns/1ps
`include "dpram_defines.vh"
module dual_port_block_ram (
    input wire i_ref_clk,
    input wire i_rstn,
    // AXI4-Lite write address
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    // AXI4-Lite write data
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    // AXI4-Lite write response
    output wire [1:0] o_bresp,
    output wire o_bvalid,
    input wire i_bready,
    // AXI4-Lite read address
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    // AXI4-Lite read data
    output wire [31:0] o_rdata,
    output wire [1:0] o_rresp,
    output wire o_rvalid,
    input wire i_rready,
    // Port A
    input wire i_port_a_clk,
    input wire i_port_a_enable,
    input wire i_port_a_write_strobe,
    input wire i_port_a_sync_output_set_reset,
    input wire [13:0] i_port_a_addr,
    input wire [31:0] i_port_a_write_data_in,
    input wire [3:0] i_port_a_write_parity_in,
    output wire [31:0] o_port_a_read_data,
    output wire [3:0] o_port_a_read_parity,
    // Port B
    input wire i_port_b_clk,
    input wire i_port_b_enable,
    input wire i_port_b_write_strobe,
    input wire i_port_b_sync_output_set_reset,
    input wire [13:0] i_port_b_addr,
    input wire [31:0] i_port_b_write_data_in,
    input wire [3:0] i_port_b_write_parity_in,
    output wire [31:0] o_port_b_read_data,
    output wire [3:0] o_port_b_read_parity
);

    // =====================================================
    // Byte-lane merge for register writes
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer k;
        begin
            merge_bytes = old_val;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
                end
            end
        end
    endfunction

    // =====================================================
    // Configuration registers
    // Per-port configuration word
    reg [15:0] cfg_a_reg;
    reg [15:0] cfg_b_reg;
    // Per-port set/reset output value, data part
    reg [31:0] srv_a_reg;
    reg [31:0] srv_b_reg;

    // =====================================================
    // Write channel state
    // Address and data are held until both have arrived
    reg aw_full_reg;
    reg w_full_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg awready_reg;
    reg wready_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;

    // =====================================================
    // Read channel state
    reg arready_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    // =====================================================
    // Per-port packed signals, index 0 is port A
    wire [1:0] p_clk;
    wire [1:0] p_en;
    wire [1:0] p_we;
    wire [1:0] p_ssr;
    wire [27:0] p_addr;
    wire [63:0] p_wdat;
    wire [7:0] p_wpar;
    wire [31:0] p_cfg;
    wire [63:0] p_srv;
    // Per-port decoded access strobes
    wire [1:0] p_hit;
    wire [1:0] p_wr;
    // Per-port mapped word index, mask and write word
    wire [8:0] p_idx [0:1];
    wire [35:0] p_mask [0:1];
    wire [35:0] p_wword [0:1];
    // Registered outputs, parity in the top four bits
    reg [35:0] dout_reg [0:1];

    // The common storage array, 512 words of 32 data + 4 parity
    reg [35:0] mem [0:511];

    assign p_clk = {i_port_b_clk, i_port_a_clk};
    assign p_en = {i_port_b_enable, i_port_a_enable};
    assign p_we = {i_port_b_write_strobe, i_port_a_write_strobe};
    assign p_ssr = {i_port_b_sync_output_set_reset, i_port_a_sync_output_set_reset};
    assign p_addr = {i_port_b_addr, i_port_a_addr};
    assign p_wdat = {i_port_b_write_data_in, i_port_a_write_data_in};
    assign p_wpar = {i_port_b_write_parity_in, i_port_a_write_parity_in};
    assign p_cfg = {cfg_b_reg, cfg_a_reg};
    assign p_srv = {srv_b_reg, srv_a_reg};

    // Merged configuration words; bits 31:16 and 11:9 do not exist and read as zero
    wire [31:0] cfg_a_new = merge_bytes({16'h0000, cfg_a_reg}, w_data_reg, w_strb_reg) & 32'h0000f1ff;
    wire [31:0] cfg_b_new = merge_bytes({16'h0000, cfg_b_reg}, w_data_reg, w_strb_reg) & 32'h0000f1ff;

    // =====================================================
    // Register write path
    // Address and data are accepted in either order, one write at a time
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            cfg_a_reg <= `CFG_RST;
            cfg_b_reg <= `CFG_RST;
            srv_a_reg <= `SRV_RST;
            srv_b_reg <= `SRV_RST;
        end else begin
            // Capture the address
            if (i_awvalid && awready_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
                awready_reg <= 1'b0;
            end
            // Capture the data
            if (i_wvalid && wready_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                wready_reg <= 1'b0;
            end
            // Both halves present: commit and answer
            if (aw_full_reg && w_full_reg && !bvalid_reg) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= `RESP_OKAY;
                if (aw_addr_reg == `OFS_CFG_A) begin
                    cfg_a_reg <= cfg_a_new[15:0];
                end else if (aw_addr_reg == `OFS_SRV_A) begin
                    srv_a_reg <= merge_bytes(srv_a_reg, w_data_reg, w_strb_reg);
                end else if (aw_addr_reg == `OFS_CFG_B) begin
                    cfg_b_reg <= cfg_b_new[15:0];
                end else if (aw_addr_reg == `OFS_SRV_B) begin
                    srv_b_reg <= merge_bytes(srv_b_reg, w_data_reg, w_strb_reg);
                end else if (aw_addr_reg == `OFS_DOUT_A || aw_addr_reg == `OFS_DOUT_B
                             || aw_addr_reg == `OFS_DPAR) begin
                    // Read-only status, the write is dropped
                    bresp_reg <= `RESP_OKAY;
                end else begin
                    // Unmapped address
                    bresp_reg <= `RESP_SLVERR;
                end
            end
            // Response taken: reopen both channels
            if (bvalid_reg && i_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // =====================================================
    // Register read path
    // One read at a time, answered the cycle after the address is taken
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_OKAY;
        end else begin
            if (i_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg <= `RESP_OKAY;
                if (i_araddr == `OFS_CFG_A) begin
                    rdata_reg <= {16'h0000, cfg_a_reg};
                end else if (i_araddr == `OFS_SRV_A) begin
                    rdata_reg <= srv_a_reg;
                end else if (i_araddr == `OFS_DOUT_A) begin
                    rdata_reg <= dout_reg[0][31:0];
                end else if (i_araddr == `OFS_CFG_B) begin
                    rdata_reg <= {16'h0000, cfg_b_reg};
                end else if (i_araddr == `OFS_SRV_B) begin
                    rdata_reg <= srv_b_reg;
                end else if (i_araddr == `OFS_DOUT_B) begin
                    rdata_reg <= dout_reg[1][31:0];
                end else if (i_araddr == `OFS_DPAR) begin
                    rdata_reg <= {24'h000000, dout_reg[1][35:32], dout_reg[0][35:32]};
                end else begin
                    // Unmapped address reads zero with an error
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= `RESP_SLVERR;
                end
            end
            if (rvalid_reg && i_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // =====================================================
    // Per-port logic, identical for both ports
    // one body for both ports
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            // Edge pulse and polarity-corrected controls
            wire edge_hit;
            wire en_act;
            wire we_act;
            wire ssr_act;
            // Mapped read and write-through values
            wire [31:0] rdat;
            wire [3:0] rpar;
            wire [31:0] wr_dat;
            wire [3:0] wr_par;
            wire [1:0] mode;

            // port clock edge as enable pulse
            port_edge_gen u_edge (
                .i_ref_clk(i_ref_clk),
                .i_rstn(i_rstn),
                .i_port_clk(p_clk[p]),
                .i_falling(p_cfg[p*16 + `CFG_CLK_FALL]),
                .o_edge(edge_hit)
            );

            assign en_act = p_en[p] ^ p_cfg[p*16 + `CFG_EN_LOW];
            assign we_act = p_we[p] ^ p_cfg[p*16 + `CFG_WE_LOW];
            assign ssr_act = p_ssr[p] ^ p_cfg[p*16 + `CFG_SSR_LOW];
            assign mode = p_cfg[p*16 + `CFG_MODE_LO +: 2];

            assign p_hit[p] = edge_hit & en_act;
            assign p_wr[p] = edge_hit & en_act & we_act;

            // each port has its own width
            // same width for write and read
            word_lane_map u_map (
                .i_width(p_cfg[p*16 + `CFG_WIDTH_LO +: 3]),
                .i_addr(p_addr[p*14 +: 14]),
                .i_wdat(p_wdat[p*32 +: 32]),
                .i_wpar(p_wpar[p*4 +: 4]),
                .i_rword(mem[p_idx[p]]),
                .o_idx(p_idx[p]),
                .o_mask(p_mask[p]),
                .o_wword(p_wword[p]),
                .o_rdat(rdat),
                .o_rpar(rpar),
                .o_wr_dat(wr_dat),
                .o_wr_par(wr_par)
            );

            // Output register of the port
            // Read happens before the array update of the same edge
            always @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    dout_reg[p] <= 36'h000000000;
                end else if (p_hit[p]) begin
                    if (ssr_act) begin
                        dout_reg[p] <= {p_cfg[p*16 + `CFG_SRPAR_LO +: 4], p_srv[p*32 +: 32]};
                    end else if (p_wr[p]) begin
                        if (mode == `MODE_WRITE_FIRST) begin
                            dout_reg[p] <= {wr_par, wr_dat};
                        end else if (mode == `MODE_READ_FIRST) begin
                            dout_reg[p] <= {rpar, rdat};
                        end else begin
                            dout_reg[p] <= dout_reg[p];
                        end
                    end else begin
                        dout_reg[p] <= {rpar, rdat};
                    end
                end
            end
        end
    endgenerate

    // =====================================================
    // Storage array update
    // both ports write one array
    // masks keep narrow ports off parity
    // Same-word writes merge so two narrow slices of one word both land;
    // a true same-location clash leaves port B's bits, which is undefined anyway
    always @(posedge i_ref_clk) begin
        if (p_wr[0] && p_wr[1] && (p_idx[0] == p_idx[1])) begin
            mem[p_idx[0]] <= (((mem[p_idx[0]] & ~p_mask[0]) | (p_wword[0] & p_mask[0]))
                              & ~p_mask[1]) | (p_wword[1] & p_mask[1]);
        end else begin
            if (p_wr[0]) begin
                mem[p_idx[0]] <= (mem[p_idx[0]] & ~p_mask[0]) | (p_wword[0] & p_mask[0]);
            end
            if (p_wr[1]) begin
                mem[p_idx[1]] <= (mem[p_idx[1]] & ~p_mask[1]) | (p_wword[1] & p_mask[1]);
            end
        end
    end

    // =====================================================
    // Outputs, each straight from a flip-flop
    // full port bus set
    // narrow data sits in the low bits
    assign o_port_a_read_data = dout_reg[0][31:0];
    assign o_port_a_read_parity = dout_reg[0][35:32];
    assign o_port_b_read_data = dout_reg[1][31:0];
    assign o_port_b_read_parity = dout_reg[1][35:32];
    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;

    // parity never generated or checked here
    // colliding accesses left to user logic
endmodule

// >>> verif/dpram_monitor.sv
// Checker of bus answers and port output timing
`timescale 1ns/1ps
module dpram_monitor (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire [1:0] o_bresp,
    input wire o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    input wire o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0] o_rresp,
    input wire o_rvalid,
    input wire i_rready,
    input wire i_port_a_clk,
    input wire [31:0] o_port_a_read_data
);
    // ====
    // One clock domain, silent in reset
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    // Read address taken
    sequence s_ar_taken;
        i_arvalid && o_arready;
    endsequence
    // Error answer with empty data
    sequence s_rd_refused;
        o_rvalid && o_rresp == 2'h2 && o_rdata == 32'h0;
    endsequence
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
        else $error("late bvalid");
    a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("bvalid dropped");
    a_write_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while answering");
    a_read_answer: assert property (s_ar_taken |=> o_rvalid)
        else $error("late rvalid");
    a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("rvalid dropped");
    a_read_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("read taken while answering");
    a_unmapped_read: assert property (s_ar_taken ##0 i_araddr > 8'h18 |=> s_rd_refused)
        else $error("unmapped read not refused");
    a_port_quiet: assert property ($stable(i_port_a_clk) |=> $stable(o_port_a_read_data))
        else $error("port output moved without edge");
endmodule
bind dual_port_block_ram dpram_monitor u_mon (.i_ref_clk, .i_rstn, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .i_port_a_clk, .o_port_a_read_data);

// >>> verif/port_user_model.sv
// Fabric logic on one memory port: clocking, requests, parity
`timescale 1ns/1ps
module port_user_model (
    input wire i_ref_clk,
    input wire [35:0] i_rd,
    output logic o_clk,
    output logic o_en,
    output logic o_we,
    output logic o_ssr,
    output logic [13:0] o_addr,
    output logic [31:0] o_wdat,
    output logic [3:0] o_wpar
);
    // ====
    // Port clock stands still between requests
    initial {o_clk, o_en, o_we, o_ssr, o_addr, o_wdat, o_wpar} = '0;
    // Idle level first, so only the second step is an active transition
    task automatic access(bit fall, bit en, bit we, bit sync_output_set_reset, logic [13:0] a, logic [31:0] d, output logic [35:0] q);
        @(posedge i_ref_clk);
        o_clk <= fall;
        {o_en, o_we, o_ssr, o_addr, o_wdat} <= {en, we, sync_output_set_reset, a, d};
        o_wpar <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
        @(posedge i_ref_clk);
        o_clk <= ~fall;
        @(posedge i_ref_clk);
        #1;
        q = i_rd;
    endtask
endmodule

// >>> verif/test_dual_port_block_ram.sv
// Self-checking bench for the dual-port block RAM
`timescale 1ns/1ps
`include "dpram_defines.vh"
module test_dual_port_block_ram;
    // ====
    // Bus, port and reference state
    logic clk = 0, rstn = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    wire awr, wrr, bv, arr, rv, ca, ea, wa, sa, cb, eb, wb, sb;
    wire [1:0] br, rr;
    wire [31:0] rd, da, db, qa, qb;
    wire [13:0] aa, ab;
    wire [3:0] pa, pb, ra, rb;
    int miscompares = 0, comparisons = 0, seed = 13;
    logic [35:0] mem [0:511];
    logic [35:0] outp [0:1];
    logic [15:0] cfg [0:1] = '{16'h0005, 16'h0005};
    logic [31:0] srv [0:1] = '{32'h0, 32'h0};
    always #2.5 clk = ~clk;
    dual_port_block_ram u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
        .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr), .o_bresp(br), .o_bvalid(bv), .i_bready(brd),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv), .i_rready(rrd),
        .i_port_a_clk(ca), .i_port_a_enable(ea), .i_port_a_write_strobe(wa), .i_port_a_sync_output_set_reset(sa),
        .i_port_a_addr(aa), .i_port_a_write_data_in(da), .i_port_a_write_parity_in(pa),
        .o_port_a_read_data(qa), .o_port_a_read_parity(ra),
        .i_port_b_clk(cb), .i_port_b_enable(eb), .i_port_b_write_strobe(wb), .i_port_b_sync_output_set_reset(sb),
        .i_port_b_addr(ab), .i_port_b_write_data_in(db), .i_port_b_write_parity_in(pb),
        .o_port_b_read_data(qb), .o_port_b_read_parity(rb));
    port_user_model u_pa (.i_ref_clk(clk), .i_rd({ra, qa}), .o_clk(ca), .o_en(ea), .o_we(wa), .o_ssr(sa),
        .o_addr(aa), .o_wdat(da), .o_wpar(pa));
    port_user_model u_pb (.i_ref_clk(clk), .i_rd({rb, qb}), .o_clk(cb), .o_en(eb), .o_we(wb), .o_ssr(sb),
        .o_addr(ab), .o_wdat(db), .o_wpar(pb));
    // ====
    task automatic chk(string nm, logic [35:0] e, logic [35:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One register transfer; d is write data or expected read data
    task automatic axi(bit w, logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int n;
        @(posedge clk);
        if (w)
            {awa, wd, awv, wv, brd} <= {a, d, 3'h7};
        else
            {ara, arv, rrd} <= {a, 2'h3};
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrr) wv <= 0;
            if (arr) arv <= 0;
            if (w ? bv : rv) break;
        end
        brd <= 0;
        rrd <= 0;
        chk("resp", er, w ? br : rr);
        if (!w) chk("rdata", d, rd);
        if (n == 40) begin
            chk("answer", 1, 0);
            print_verdict();
        end
    endtask
    task automatic set_cfg(int p, logic [15:0] v);
        cfg[p] = v;
        axi(1, p ? `OFS_CFG_B : `OFS_CFG_A, {16'h0, v}, 0);
    endtask
    // Little-endian lane of one storage word; optional write first
    function automatic logic [35:0] lane(int c, int a, bit wr, logic [35:0] v);
        int dw, pw, r;
        dw = 1 << c;
        pw = c < 3 ? 0 : 1 << (c - 3);
        r = 32 / dw;
        lane = 36'h0;
        for (int k = 0; k < dw + pw; k++) begin
            if (wr) mem[a / r][k < dw ? (a % r) * dw + k : 32 + (a % r) * pw + k - dw] = v[k < dw ? k : 32 + k - dw];
            lane[k < dw ? k : 32 + k - dw] = mem[a / r][k < dw ? (a % r) * dw + k : 32 + (a % r) * pw + k - dw];
        end
    endfunction
    // One port request and the reference's view of it
    task automatic op(int p, bit en, bit we, bit sync_output_set_reset, int a, logic [31:0] d);
        logic [35:0] q, old;
        bit e, w, s;
        int c;
        c = cfg[p][2:0];
        if (p == 0)
            u_pa.access(cfg[0][5], en, we, sync_output_set_reset, a[13:0], d, q);
        else
            u_pb.access(cfg[1][5], en, we, sync_output_set_reset, a[13:0], d, q);
        e = en ^ cfg[p][6];
        w = e & (we ^ cfg[p][7]);
        s = e & (sync_output_set_reset ^ cfg[p][8]);
        old = lane(c, a, 0, 0);
        if (w) void'(lane(c, a, 1, {p ? pb : pa, d}));
        if (s)
            outp[p] = {cfg[p][15:12], srv[p]};
        else if (e && !(w && cfg[p][4]))
            outp[p] = (w && cfg[p][3]) ? old : lane(c, a, 0, 0);
        chk("port output", outp[p], q);
    endtask
    // ====
    // Main sequence; one port busy at a time
    initial begin
        int a;
        repeat (20) @(posedge clk);
        rstn <= 1;
        axi(0, `OFS_CFG_A, 32'h5, `RESP_OKAY);
        axi(0, `OFS_SRV_B, 32'h0, `RESP_OKAY);
        axi(0, 8'h40, 32'h0, `RESP_SLVERR);
        axi(1, 8'h40, 32'h1, `RESP_SLVERR);
        axi(1, `OFS_CFG_A, 32'hffffae05, `RESP_OKAY);
        cfg[0] = 16'ha005;
        axi(0, `OFS_CFG_A, 32'ha005, `RESP_OKAY);
        $display("test registers done");
        for (a = 0; a < 8; a++) op(0, 1, 1, 0, a, $random(seed));
        op(0, 1, 1, 0, 511, $random(seed));
        for (int c = 0; c < 6; c++) begin
            set_cfg(1, 16'(c));
            op(1, 1, 0, 0, (512 << (5 - c)) - 1, 0);
            repeat (6) op(1, 1, $random(seed), 0, $unsigned($random(seed)) % (8 << (5 - c)), $random(seed));
        end
        for (a = 0; a < 8; a++) op(0, 1, 0, 0, a, 0);
        $display("test widths done");
        for (int m = 0; m < 4; m++) begin
            set_cfg(0, {11'h0, m[1:0], 3'h5});
            op(0, 1, 1, 0, 3, $random(seed));
            op(0, 0, 1, 1, 4, 0);
        end
        // Inverted controls on the falling edge
        set_cfg(0, 16'h01e5);
        op(0, 0, 0, 1, 6, $random(seed));
        op(0, 1, 0, 1, 6, 0);
        op(0, 0, 1, 1, 6, 0);
        srv[0] = $random(seed);
        axi(1, `OFS_SRV_A, srv[0], `RESP_OKAY);
        set_cfg(0, 16'ha005);
        op(0, 1, 1, 1, 2, $random(seed));
        op(0, 1, 0, 0, 2, 0);
        axi(1, `OFS_DOUT_A, 32'h0, `RESP_OKAY);
        axi(0, `OFS_DOUT_A, outp[0][31:0], `RESP_OKAY);
        axi(0, `OFS_DPAR, {24'h0, outp[1][35:32], outp[0][35:32]}, `RESP_OKAY);
        $display("test controls done");
        print_verdict();
    end
endmodule
